// ===== core/i2cs_pkg.sv
// Constants and types for the I2C slave state handling block
//
// Function
// - Own-address byte NACKed: 0x88, drop, unaddress
// - Set-bits write 0x04 sets only acknowledge flag
// - Clear-bits write 0x08 clears event flag, proceeds
// - General-call byte ACKed: 0x90, byte kept
// - Clear-bits 0x0C clears event and acknowledge flags
// - General-call byte NACKed: 0x98, drop, unaddress
// - STOP or restart while addressed: 0xA0, unaddress
// - Own address read ACKed: 0xA8, then transmit
// - Lost arbitration then own read: 0xB0
// - Set-bits 0x24 sets start and acknowledge flags
// - Sent byte ACKed: 0xB8, send next byte
// - Sent byte NACKed: 0xC0, unaddress
// - Last byte ACKed: 0xC8, unaddress
// - Own address write ACKed: 0x60, receive
// - General call ACKed: 0x70, receive
// - Own-address byte ACKed: 0x80, byte kept
`default_nettype none
package i2cs_pkg;
  localparam logic [7:0] OFS_SET = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_ADR = 8'h0c;
  localparam logic [7:0] OFS_CLR = 8'h18;
  localparam logic [7:0] OFS_IST = 8'h1c;
  localparam logic [7:0] OFS_IMASK = 8'h20;
  localparam int BIT_ACK = 2;
  localparam int BIT_SI = 3;
  localparam int BIT_START = 5;
  localparam int BIT_EN = 6;
  localparam int ADR_GC = 0;
  localparam int IRQ_EV = 0;
  localparam int IRQ_STOP = 1;
  localparam logic [7:0] C_ACK = 8'h04;
  localparam logic [7:0] C_SI = 8'h08;
  localparam logic [7:0] C_SI_ACK = 8'h0c;
  localparam logic [7:0] C_START_ACK = 8'h24;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] S_IDLE = 8'hf8;
  localparam logic [7:0] S_OWN_W = 8'h60;
  localparam logic [7:0] S_ARB_W = 8'h68;
  localparam logic [7:0] S_GC = 8'h70;
  localparam logic [7:0] S_ARB_GC = 8'h78;
  localparam logic [7:0] S_OWN_ACK = 8'h80;
  localparam logic [7:0] S_OWN_NACK = 8'h88;
  localparam logic [7:0] S_GC_ACK = 8'h90;
  localparam logic [7:0] S_GC_NACK = 8'h98;
  localparam logic [7:0] S_STOP = 8'ha0;
  localparam logic [7:0] S_OWN_R = 8'ha8;
  localparam logic [7:0] S_ARB_R = 8'hb0;
  localparam logic [7:0] S_TX_ACK = 8'hb8;
  localparam logic [7:0] S_TX_NACK = 8'hc0;
  localparam logic [7:0] S_TX_LAST = 8'hc8;
  localparam logic [7:0] ADR_RST = 8'h00;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_RX = 7'h08,
    ST_RACK = 7'h10,
    ST_TX = 7'h20,
    ST_TACK = 7'h40
  } state_type;

  typedef struct packed {
    logic en;
    logic start;
    logic si;
    logic ack;
  } ctrl_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } pins_type;

  function automatic logic [7:0] ctrl_byte(input ctrl_type c);
    logic [7:0] b;
    b = 8'h00;
    b[BIT_ACK] = c.ack;
    b[BIT_SI] = c.si;
    b[BIT_START] = c.start;
    b[BIT_EN] = c.en;
    return b;
  endfunction : ctrl_byte
endpackage : i2cs_pkg
`default_nettype wire

// ===== core/i2c_slave_state_handling.sv
// I2C slave receiver and transmitter with status codes and APB registers
//
// Our own choices: the register addresses and the APB interface to the registers.
`default_nettype none
module i2c_slave_state_handling (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  input wire logic scl_i, // Bus clock level
  output logic scl_o, // Bus clock drive value
  output logic scl_oe_n, // Bus clock pull low
  input wire logic sda_i, // Bus data level
  output logic sda_o, // Bus data drive value
  output logic sda_oe_n, // Bus data pull low
  input wire logic arb_lost, // Master lost arbitration
  output logic start_req, // Master start request
  output logic irq // Interrupt level
);
  i2cs_pkg::ctrl_type ctrl_q, ctrl_d;
  i2cs_pkg::state_type st_q, st_d;
  i2cs_pkg::pins_type sy1_q, sy2_q, syp_q;
  logic [7:0] stat_q, stat_d, dat_q, dat_d, adr_q, adr_d, sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic [1:0] ist_q, ist_d, imask_q, imask_d;
  logic [31:0] prdata_q, prdata_d;
  logic slverr_q, slverr_d, gc_q, gc_d, last_q, last_d, nack_q, nack_d;
  logic pend_q, pend_d, busy_q, busy_d, sdaoe_q, sdaoe_d, scloe_q, scloe_d;
  logic wr, set_w, clr_w, ev, rise, fall, start_c, stop_c, addressed;
  logic [7:0] ev_code;

  // Pins are foreign to pclk: two flops before any use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy1_q <= '1;
      sy2_q <= '1;
      syp_q <= '1;
    end else begin
      sy1_q <= '{scl: scl_i, sda: sda_i};
      sy2_q <= sy1_q;
      syp_q <= sy2_q;
    end
  end

  assign rise = sy2_q.scl && !syp_q.scl;
  assign fall = !sy2_q.scl && syp_q.scl;
  assign start_c = sy2_q.scl && syp_q.scl && !sy2_q.sda && syp_q.sda;
  assign stop_c = sy2_q.scl && syp_q.scl && sy2_q.sda && !syp_q.sda;
  assign addressed = !(st_q inside {i2cs_pkg::ST_IDLE, i2cs_pkg::ST_ADDR});
  assign wr = psel && penable && pwrite;
  assign set_w = wr && paddr == i2cs_pkg::OFS_SET;
  assign clr_w = wr && paddr == i2cs_pkg::OFS_CLR;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    gc_d = gc_q;
    last_d = last_q;
    nack_d = nack_q;
    pend_d = pend_q;
    sdaoe_d = sdaoe_q;
    busy_d = busy_q;
    ev = 1'b0;
    ev_code = stat_q;
    if (start_c || stop_c) begin
      if (addressed) begin
        ev = 1'b1;
        ev_code = i2cs_pkg::S_STOP;
      end
      busy_d = start_c;
      st_d = start_c ? i2cs_pkg::ST_ADDR : i2cs_pkg::ST_IDLE;
      cnt_d = 4'h0;
      pend_d = 1'b0;
      sdaoe_d = 1'b1;
    end else begin
      case (st_q)
        i2cs_pkg::ST_IDLE: begin
          sdaoe_d = 1'b1;
        end
        i2cs_pkg::ST_ADDR: begin
          if (rise) begin
            sh_d = {sh_q[6:0], sy2_q.sda};
            cnt_d = cnt_q + 4'h1;
          end else if (fall && cnt_q == i2cs_pkg::BYTE_BITS) begin
            gc_d = sh_q == 8'h00 && adr_q[i2cs_pkg::ADR_GC];
            if (ctrl_q.ack && (gc_d || sh_q[7:1] == adr_q[7:1])) begin
              st_d = i2cs_pkg::ST_AACK;
              sdaoe_d = 1'b0;
            end else begin
              st_d = i2cs_pkg::ST_IDLE;
            end
          end
        end
        i2cs_pkg::ST_AACK: begin
          if (fall) begin
            sdaoe_d = 1'b1;
            ev = 1'b1;
            cnt_d = 4'h0;
            if (sh_q[0] && !gc_q) begin
              ev_code = arb_lost ? i2cs_pkg::S_ARB_R
                                 : i2cs_pkg::S_OWN_R;
              st_d = i2cs_pkg::ST_TX;
              pend_d = 1'b1;
            end else begin
              st_d = i2cs_pkg::ST_RX;
              if (gc_q) begin
                ev_code = arb_lost ? i2cs_pkg::S_ARB_GC
                                   : i2cs_pkg::S_GC;
              end else begin
                ev_code = arb_lost ? i2cs_pkg::S_ARB_W
                                   : i2cs_pkg::S_OWN_W;
              end
            end
          end
        end
        i2cs_pkg::ST_RX: begin
          if (rise) begin
            sh_d = {sh_q[6:0], sy2_q.sda};
            cnt_d = cnt_q + 4'h1;
          end else if (fall && cnt_q == i2cs_pkg::BYTE_BITS) begin
            st_d = i2cs_pkg::ST_RACK;
            nack_d = !ctrl_q.ack;
            sdaoe_d = !ctrl_q.ack;
          end
        end
        i2cs_pkg::ST_RACK: begin
          if (fall) begin
            sdaoe_d = 1'b1;
            ev = 1'b1;
            cnt_d = 4'h0;
            if (nack_q) begin
              ev_code = gc_q ? i2cs_pkg::S_GC_NACK
                             : i2cs_pkg::S_OWN_NACK;
              st_d = i2cs_pkg::ST_IDLE;
            end else begin
              ev_code = gc_q ? i2cs_pkg::S_GC_ACK
                             : i2cs_pkg::S_OWN_ACK;
              st_d = i2cs_pkg::ST_RX;
            end
          end
        end
        i2cs_pkg::ST_TX: begin
          // Byte taken only once software has cleared the event flag
          if (pend_q) begin
            if (!ctrl_q.si) begin
              sh_d = dat_q;
              last_d = !ctrl_q.ack;
              sdaoe_d = dat_q[7];
              pend_d = 1'b0;
              cnt_d = 4'h0;
            end
          end else if (rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (fall) begin
            if (cnt_q == i2cs_pkg::BYTE_BITS) begin
              st_d = i2cs_pkg::ST_TACK;
              sdaoe_d = 1'b1;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              sdaoe_d = sh_q[6];
            end
          end
        end
        i2cs_pkg::ST_TACK: begin
          if (rise) begin
            nack_d = sy2_q.sda;
          end else if (fall) begin
            ev = 1'b1;
            st_d = i2cs_pkg::ST_IDLE;
            if (nack_q) begin
              ev_code = i2cs_pkg::S_TX_NACK;
            end else if (last_q) begin
              ev_code = i2cs_pkg::S_TX_LAST;
            end else begin
              ev_code = i2cs_pkg::S_TX_ACK;
              st_d = i2cs_pkg::ST_TX;
              pend_d = 1'b1;
            end
          end
        end
        default: begin
          st_d = i2cs_pkg::ST_IDLE;
        end
      endcase
    end
    if (!ctrl_q.en) begin
      st_d = i2cs_pkg::ST_IDLE;
      ev = 1'b0;
      pend_d = 1'b0;
      sdaoe_d = 1'b1;
    end
    stat_d = ev ? ev_code : stat_q;

    ctrl_d = ctrl_q;
    if (set_w) begin
      ctrl_d.ack = ctrl_q.ack | pwdata[i2cs_pkg::BIT_ACK];
      ctrl_d.start = ctrl_q.start | pwdata[i2cs_pkg::BIT_START];
      ctrl_d.en = ctrl_q.en | pwdata[i2cs_pkg::BIT_EN];
    end
    if (clr_w) begin
      ctrl_d.ack = ctrl_q.ack & !pwdata[i2cs_pkg::BIT_ACK];
      ctrl_d.start = ctrl_q.start & !pwdata[i2cs_pkg::BIT_START];
      ctrl_d.en = ctrl_q.en & !pwdata[i2cs_pkg::BIT_EN];
    end
    // A new event wins over a clear in the same cycle
    ctrl_d.si = (ctrl_q.si && !(clr_w && pwdata[i2cs_pkg::BIT_SI])) || ev;
    // Data pushed out a cycle before the clock is let go
    // Hold starts only on a low clock: pulling a high line after a STOP
    // or repeated START would fake a clock pulse on release
    scloe_d = !((ctrl_d.si && (!scloe_q || !sy2_q.scl)) || pend_q);

    dat_d = dat_q;
    if (wr && paddr == i2cs_pkg::OFS_DATA) begin
      dat_d = pwdata[7:0];
    end
    if (ev && !nack_q && st_q == i2cs_pkg::ST_RACK) begin
      dat_d = sh_q;
    end
    adr_d = adr_q;
    if (wr && paddr == i2cs_pkg::OFS_ADR) begin
      adr_d = pwdata[7:0];
    end
    imask_d = imask_q;
    if (wr && paddr == i2cs_pkg::OFS_IMASK) begin
      imask_d = pwdata[1:0];
    end
    ist_d = ist_q;
    if (wr && paddr == i2cs_pkg::OFS_IST) begin
      ist_d = ist_q & ~pwdata[1:0];
    end
    ist_d[i2cs_pkg::IRQ_EV] = ist_d[i2cs_pkg::IRQ_EV] | ev;
    ist_d[i2cs_pkg::IRQ_STOP] = ist_d[i2cs_pkg::IRQ_STOP] | stop_c;

    // Read data and error are built in the setup phase
    prdata_d = prdata_q;
    slverr_d = slverr_q;
    if (psel && !penable) begin
      prdata_d = 32'h0000_0000;
      slverr_d = 1'b0;
      case (paddr)
        i2cs_pkg::OFS_SET: prdata_d[7:0] = i2cs_pkg::ctrl_byte(ctrl_q);
        i2cs_pkg::OFS_STAT: prdata_d[7:0] = stat_q;
        i2cs_pkg::OFS_DATA: prdata_d[7:0] = dat_q;
        i2cs_pkg::OFS_ADR: prdata_d[7:0] = adr_q;
        i2cs_pkg::OFS_CLR: prdata_d[7:0] = 8'h00;
        i2cs_pkg::OFS_IST: prdata_d[1:0] = ist_q;
        i2cs_pkg::OFS_IMASK: prdata_d[1:0] = imask_q;
        default: slverr_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      st_q <= i2cs_pkg::ST_IDLE;
      stat_q <= i2cs_pkg::S_IDLE;
      dat_q <= 8'h00;
      adr_q <= i2cs_pkg::ADR_RST;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      ist_q <= 2'h0;
      imask_q <= 2'h0;
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
      gc_q <= 1'b0;
      last_q <= 1'b0;
      nack_q <= 1'b0;
      pend_q <= 1'b0;
      busy_q <= 1'b0;
      sdaoe_q <= 1'b1;
      scloe_q <= 1'b1;
    end else begin
      ctrl_q <= ctrl_d;
      st_q <= st_d;
      stat_q <= stat_d;
      dat_q <= dat_d;
      adr_q <= adr_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      prdata_q <= prdata_d;
      slverr_q <= slverr_d;
      gc_q <= gc_d;
      last_q <= last_d;
      nack_q <= nack_d;
      pend_q <= pend_d;
      busy_q <= busy_d;
      sdaoe_q <= sdaoe_d;
      scloe_q <= scloe_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = slverr_q;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n = scloe_q;
  assign sda_oe_n = sdaoe_q;
  assign start_req = ctrl_q.start && !busy_q;
  assign irq = |(ist_q & imask_q);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_OWN_NACK: assert property ($rose(ctrl_q.si) && stat_q ==
    i2cs_pkg::S_OWN_NACK |-> st_q == i2cs_pkg::ST_IDLE && sda_oe_n)
    else $error("0x88 did not unaddress");
  AST_SET_ACK: assert property (set_w && pwdata[7:0] == i2cs_pkg::C_ACK
    |=> ctrl_q.ack && ctrl_q.start == $past(ctrl_q.start))
    else $error("set 0x04 wrong");
  AST_CLR_SI: assert property (clr_w && pwdata[7:0] == i2cs_pkg::C_SI
    && !ev |=> !ctrl_q.si)
    else $error("event flag not cleared");
  AST_GC_ACK: assert property ($rose(ctrl_q.si) && stat_q ==
    i2cs_pkg::S_GC_ACK |-> dat_q == $past(sh_q) && st_q == i2cs_pkg::ST_RX)
    else $error("0x90 byte not kept");
  AST_CLR_BOTH: assert property (clr_w && pwdata[7:0] ==
    i2cs_pkg::C_SI_ACK && !ev |=> !ctrl_q.si && !ctrl_q.ack)
    else $error("clear 0x0c wrong");
  AST_GC_NACK: assert property ($rose(ctrl_q.si) && stat_q ==
    i2cs_pkg::S_GC_NACK |-> st_q == i2cs_pkg::ST_IDLE)
    else $error("0x98 did not unaddress");
  AST_STOP: assert property ((start_c || stop_c) && addressed &&
    ctrl_q.en |=> ctrl_q.si && stat_q == i2cs_pkg::S_STOP && !addressed)
    else $error("0xa0 missing");
  AST_READ: assert property ($rose(ctrl_q.si) && stat_q ==
    i2cs_pkg::S_OWN_R |-> st_q == i2cs_pkg::ST_TX && pend_q)
    else $error("0xa8 not transmitting");
  AST_ARB_R: assert property ($rose(ctrl_q.si) && stat_q ==
    i2cs_pkg::S_ARB_R |-> $past(arb_lost) && st_q == i2cs_pkg::ST_TX)
    else $error("0xb0 without lost arbitration");
  AST_START: assert property (set_w && pwdata[7:0] ==
    i2cs_pkg::C_START_ACK |=> ctrl_q.start && ctrl_q.ack ##0
    start_req == !busy_q)
    else $error("set 0x24 wrong");
  AST_TX_ACK: assert property ($rose(ctrl_q.si) && stat_q ==
    i2cs_pkg::S_TX_ACK |-> st_q == i2cs_pkg::ST_TX && pend_q)
    else $error("0xb8 not continuing");
  AST_TX_NACK: assert property ($rose(ctrl_q.si) && stat_q ==
    i2cs_pkg::S_TX_NACK |-> st_q == i2cs_pkg::ST_IDLE)
    else $error("0xc0 did not unaddress");
  AST_TX_LAST: assert property ($rose(ctrl_q.si) && stat_q ==
    i2cs_pkg::S_TX_LAST |-> st_q == i2cs_pkg::ST_IDLE && $past(last_q))
    else $error("0xc8 wrong");
  AST_STRETCH: assert property ((ctrl_q.si && !sy2_q.scl) ##1 ctrl_q.si
    |-> !scl_oe_n)
    else $error("clock not held");
  AST_OWN_W: assert property ($rose(ctrl_q.si) && stat_q ==
    i2cs_pkg::S_OWN_W |-> st_q == i2cs_pkg::ST_RX && !gc_q)
    else $error("0x60 not receiving");
  AST_GC: assert property ($rose(ctrl_q.si) && stat_q ==
    i2cs_pkg::S_GC |-> st_q == i2cs_pkg::ST_RX && gc_q)
    else $error("0x70 not receiving");
  AST_OWN_ACK: assert property ($rose(ctrl_q.si) && stat_q ==
    i2cs_pkg::S_OWN_ACK |-> dat_q == $past(sh_q))
    else $error("0x80 byte not kept");

  COV_WRITE: cover property ($rose(ctrl_q.si) &&
    stat_q == i2cs_pkg::S_OWN_ACK);
  COV_READ: cover property ($rose(ctrl_q.si) &&
    stat_q == i2cs_pkg::S_TX_ACK);
  COV_STOP: cover property ($rose(ctrl_q.si) && stat_q == i2cs_pkg::S_STOP);
  COV_GC: cover property ($rose(ctrl_q.si) &&
    stat_q == i2cs_pkg::S_GC_NACK);
endmodule : i2c_slave_state_handling
`default_nettype wire

// ===== verif/i2c_master_model.sv
// Behavioural I2C bus master facing the slave's pins
`default_nettype none
module i2c_master_model (
  output var logic scl_d, // Clock drive, 0 pulls low
  output var logic sda_d, // Data drive, 0 pulls low
  input wire logic scl, // Resolved clock line
  input wire logic sda // Resolved data line
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 80;
  initial begin
    scl_d = 1'b1;
    sda_d = 1'b1;
  end
  // High phase is timed only once stretching has ended
  task automatic rise();
    scl_d = 1'b1;
    wait (scl === 1'b1);
    #HALF;
  endtask : rise
  // Serves a first start and a repeated start alike
  task automatic start_cond();
    sda_d = 1'b1;
    #HALF;
    rise();
    sda_d = 1'b0;
    #HALF;
  endtask : start_cond
  task automatic stop_cond();
    scl_d = 1'b0;
    #HALF;
    sda_d = 1'b0;
    #HALF;
    rise();
    sda_d = 1'b1;
    #HALF;
  endtask : stop_cond
  task automatic bit_cyc(input logic b, output logic s);
    scl_d = 1'b0;
    #HALF;
    sda_d = b;
    #HALF;
    rise();
    s = sda;
  endtask : bit_cyc
  // Eight bits MSB first, then acknowledge; clock left low
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
      output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(tx[i], rx[i]);
    end
    bit_cyc(ack_in, ack_out);
    scl_d = 1'b0;
  endtask : xfer
endmodule : i2c_master_model
`default_nettype wire

// ===== verif/test_i2c_slave_state_handling.sv
// Bench: APB service routine against an I2C bus master model
`default_nettype none
module test_i2c_slave_state_handling;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] OWN_WR = 8'h54;
  localparam logic [7:0] OWN_RD = 8'h55;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, arb_lost = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, scl_o, scl_oe_n, sda_o, sda_oe_n;
  logic start_req, irq, m_scl, m_sda, err;
  wire scl_w, sda_w;
  int fails = 0;
  int total_checks = 0;

  always #5 pclk = ~pclk;
  // Pulled-up open-drain lines: any low driver wins
  assign scl_w = m_scl & (scl_oe_n | scl_o);
  assign sda_w = m_sda & (sda_oe_n | sda_o);

  i2c_slave_state_handling dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .arb_lost(arb_lost), .start_req(start_req),
    .irq(irq));
  i2c_master_model m (.scl_d(m_scl), .sda_d(m_sda), .scl(scl_w),
    .sda(sda_w));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    chk({31'h0, pready}, 32'h1, "apb ready");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, rd, err);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp,
      input string what);
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, {24'h0, exp}, what);
  endtask : rdchk

  task automatic wait_oe(input logic lvl, input string what);
    int n;
    n = 0;
    @(negedge pclk);
    while (scl_oe_n !== lvl && n < 200) begin
      @(negedge pclk);
      n++;
    end
    chk({31'h0, scl_oe_n}, {31'h0, lvl}, what);
  endtask : wait_oe

  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic [7:0] r;
    logic a;
    m.xfer(b, 1'b1, r, a);
    chk({31'h0, a}, {31'h0, exp_ack}, "ack bit");
  endtask : send

  task automatic recv(input logic [7:0] exp, input logic mack);
    logic [7:0] r;
    logic a;
    m.xfer(8'hff, mack, r, a);
    chk({24'h0, r}, {24'h0, exp}, "sent byte");
  endtask : recv

  task automatic svc(input logic [7:0] st, input logic ld,
      input logic [7:0] d, input logic [7:0] setv, input logic [7:0] clrv);
    int n;
    n = 0;
    @(negedge pclk);
    while (irq !== 1'b1 && n < 200) begin
      @(negedge pclk);
      n++;
    end
    chk({31'h0, irq}, 32'h1, "irq");
    // Only a clock that the master holds low gets stretched
    chk({31'h0, scl_oe_n}, {31'h0, m_scl}, "clock held");
    rdchk(i2cs_pkg::OFS_STAT, st, "status");
    if (ld) wr(i2cs_pkg::OFS_DATA, d);
    if (setv != 8'h00) wr(i2cs_pkg::OFS_SET, setv);
    wr(i2cs_pkg::OFS_IST, 8'h03);
    wr(i2cs_pkg::OFS_CLR, clrv);
    if (clrv[3]) wait_oe(1'b1, "clock released");
  endtask : svc

  task automatic stop_idle();
    int n;
    n = 0;
    m.stop_cond();
    while (irq !== 1'b1 && n < 200) begin
      @(negedge pclk);
      n++;
    end
    rdchk(i2cs_pkg::OFS_IST, 8'h02, "stop seen");
    wr(i2cs_pkg::OFS_IST, 8'h03);
  endtask : stop_idle

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(i2cs_pkg::OFS_STAT, i2cs_pkg::S_IDLE, "reset status");
    rdchk(i2cs_pkg::OFS_SET, 8'h00, "reset control");
    rdchk(i2cs_pkg::OFS_ADR, i2cs_pkg::ADR_RST, "reset address");
    apb(1'b0, 8'h10, 32'h0, rd, err);
    chk(rd, 32'h0, "unmapped data");
    chk({31'h0, err}, 32'h1, "unmapped error");
    wr(i2cs_pkg::OFS_ADR, 8'h55);
    wr(i2cs_pkg::OFS_IMASK, 8'h00);
    wr(i2cs_pkg::OFS_SET, 8'h44);
    $display("test registers done");
    m.start_cond();
    send(OWN_WR, 1'b0);
    wait_oe(1'b0, "clock held");
    chk({31'h0, irq}, 32'h0, "masked irq");
    wr(i2cs_pkg::OFS_IMASK, 8'h03);
    svc(i2cs_pkg::S_OWN_W, 0, 0, i2cs_pkg::C_ACK, i2cs_pkg::C_SI);
    send(8'ha5, 1'b0);
    svc(i2cs_pkg::S_OWN_ACK, 0, 0, 0, i2cs_pkg::C_SI_ACK);
    rdchk(i2cs_pkg::OFS_DATA, 8'ha5, "own byte");
    rdchk(i2cs_pkg::OFS_SET, 8'h40, "ack flag cleared");
    send(8'h3c, 1'b1);
    svc(i2cs_pkg::S_OWN_NACK, 0, 0, i2cs_pkg::C_ACK, i2cs_pkg::C_SI);
    rdchk(i2cs_pkg::OFS_DATA, 8'ha5, "byte dropped");
    rdchk(i2cs_pkg::OFS_SET, 8'h44, "only ack set");
    send(8'h11, 1'b1);
    // Status keeps its last code; no new event means not addressed
    rdchk(i2cs_pkg::OFS_IST, 8'h00, "unaddressed");
    stop_idle();
    $display("test own write done");
    m.start_cond();
    send(8'h00, 1'b0);
    svc(i2cs_pkg::S_GC, 0, 0, i2cs_pkg::C_ACK, i2cs_pkg::C_SI);
    send(8'h66, 1'b0);
    svc(i2cs_pkg::S_GC_ACK, 0, 0, 0, i2cs_pkg::C_SI_ACK);
    rdchk(i2cs_pkg::OFS_DATA, 8'h66, "call byte");
    send(8'h77, 1'b1);
    svc(i2cs_pkg::S_GC_NACK, 0, 0, i2cs_pkg::C_ACK, i2cs_pkg::C_SI);
    rdchk(i2cs_pkg::OFS_DATA, 8'h66, "call byte dropped");
    send(8'h12, 1'b1);
    stop_idle();
    $display("test general call done");
    m.start_cond();
    send(OWN_WR, 1'b0);
    svc(i2cs_pkg::S_OWN_W, 0, 0, i2cs_pkg::C_ACK, i2cs_pkg::C_SI);
    m.stop_cond();
    svc(i2cs_pkg::S_STOP, 0, 0, i2cs_pkg::C_ACK, i2cs_pkg::C_SI);
    m.start_cond();
    send(OWN_WR, 1'b0);
    svc(i2cs_pkg::S_OWN_W, 0, 0, i2cs_pkg::C_ACK, i2cs_pkg::C_SI);
    m.start_cond();
    svc(i2cs_pkg::S_STOP, 0, 0, i2cs_pkg::C_ACK, i2cs_pkg::C_SI);
    send(OWN_RD, 1'b0);
    svc(i2cs_pkg::S_OWN_R, 1, 8'hc3, i2cs_pkg::C_ACK, 8'h08);
    recv(8'hc3, 1'b0);
    svc(i2cs_pkg::S_TX_ACK, 1, 8'h5a, 0, i2cs_pkg::C_ACK);
    wr(i2cs_pkg::OFS_CLR, i2cs_pkg::C_SI);
    wait_oe(1'b1, "clock released");
    recv(8'h5a, 1'b0);
    svc(i2cs_pkg::S_TX_LAST, 0, 0, i2cs_pkg::C_ACK, i2cs_pkg::C_SI);
    stop_idle();
    $display("test stop and transmit done");
    m.start_cond();
    @(posedge pclk);
    arb_lost <= 1'b1;
    send(OWN_RD, 1'b0);
    svc(i2cs_pkg::S_ARB_R, 1, 8'h96, i2cs_pkg::C_START_ACK, 8'h08);
    rdchk(i2cs_pkg::OFS_SET, 8'h64, "start and ack set");
    chk({31'h0, start_req}, 32'h0, "busy bus");
    @(posedge pclk);
    arb_lost <= 1'b0;
    recv(8'h96, 1'b1);
    svc(i2cs_pkg::S_TX_NACK, 0, 0, i2cs_pkg::C_ACK, i2cs_pkg::C_SI);
    stop_idle();
    @(negedge pclk);
    chk({31'h0, start_req}, 32'h1, "retry on free bus");
    wr(i2cs_pkg::OFS_CLR, 8'h20);
    @(negedge pclk);
    chk({31'h0, start_req}, 32'h0, "retry withdrawn");
    $display("test lost arbitration done");
    stop_test();
  end

  // Whole run needs well under this span
  initial begin
    #500000;
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule : test_i2c_slave_state_handling
`default_nettype wire
